// ---- odu_overhead_field_codec_tb_top.sv ----
// bench for the overhead codec: tx encode, message memories, rx decode
// assumes ooc_remote_ne stands in for the far element on the rx side
`timescale 1ns/1ps
module odu_overhead_field_codec_tb_top;
    logic       mclk, rst_n = 1'b0, tx_frame = 1'b0, sig_fail = 1'b0;
    logic       psi_direct = 1'b0, wr_en = 1'b0, wr_ftfl = 1'b0;
    logic [7:0] tx_mfas = 8'h00, psi_value = 8'h00;
    logic [7:0] wr_addr = 8'h00, wr_data = 8'h00;
    logic [3:0] bip_err_cnt = 4'h0, aps_req = 4'h0, aps_ptype = 4'h0;
    ooc_pkg::ooc_maint_t    pm_maint   = ooc_pkg::MNT_NORMAL;
    ooc_pkg::ooc_tcm_stat_t tcm_mode   = ooc_pkg::TCS_NOSRC;
    ooc_pkg::ooc_psi_t      psi_select = ooc_pkg::PSI_GFP;
    logic [7:0] tx_pm_b3, tx_tcm_b3, tx_aps_b0, tx_psi0, tx_tti_byte;
    logic [7:0] tx_ftfl_byte, rx_mfas, rx_pm_b3, rx_tcm_b3, rx_aps_b0;
    logic [7:0] rx_psi0, rx_ftfl_byte;
    logic       rx_frame, rx_bdi, rx_cc_ok, rx_nsc_ok;
    logic [3:0] rx_bei, rx_ptype;
    logic [2:0] rx_nsc_len;
    ooc_pkg::ooc_tcm_stat_t rx_tcm_stat;
    ooc_pkg::ooc_psi_t      rx_psi;
    ooc_pkg::ooc_pm_stat_t  rx_pm_stat;
    ooc_pkg::ooc_aps_t      rx_aps;
    ooc_pkg::ooc_fault_t    rx_fwd_fault, rx_bwd_fault;
    int n_mismatch = 0;
    int checks_done = 0;
    localparam logic [2:0] PM_TX [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
    localparam logic [2:0] TCM_TX [7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6,
        3'h7, 3'h0};
    localparam logic [7:0] PSI_TX [11] = '{8'h02, 8'h03, 8'h05, 8'h20,
        8'h21, 8'h80, 8'hFD, 8'hFE, 8'hFF, 8'hFF, 8'hFF};
    localparam logic [7:0] PSI_IN [16] = '{8'h02, 8'h03, 8'h05, 8'h20,
        8'h21, 8'h80, 8'hFD, 8'hFE, 8'h01, 8'h1C, 8'h55, 8'h66, 8'hFF,
        8'h1D, 8'h00, 8'h04};
    localparam logic [3:0] PSI_DEC [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 8,
        9, 9, 9, 10, 10, 8};
    localparam logic [2:0] PM_DEC [8] = '{4, 0, 4, 4, 4, 1, 2, 3};
    localparam logic [2:0] TCM_DEC [8] = '{0, 1, 2, 6, 6, 3, 4, 5};
    localparam logic [3:0] APS_DEC [16] = '{0, 1, 2, 10, 3, 10, 4, 10, 5,
        10, 6, 10, 7, 10, 8, 9};

    ooc_codec i_ooc_codec (
        .mclk, .rst_n, .tx_frame, .tx_mfas, .sig_fail, .bip_err_cnt,
        .pm_maint, .tcm_mode, .aps_req, .aps_ptype, .psi_direct,
        .psi_value, .psi_select, .wr_en, .wr_ftfl, .wr_addr, .wr_data,
        .tx_pm_b3, .tx_tcm_b3, .tx_aps_b0, .tx_psi0, .tx_tti_byte,
        .tx_ftfl_byte, .rx_frame, .rx_mfas, .rx_pm_b3, .rx_tcm_b3,
        .rx_aps_b0, .rx_psi0, .rx_ftfl_byte, .rx_bei, .rx_bdi, .rx_pm_stat,
        .rx_tcm_stat, .rx_aps, .rx_ptype, .rx_psi, .rx_fwd_fault,
        .rx_bwd_fault, .rx_cc_ok, .rx_nsc_len, .rx_nsc_ok
    );
    ooc_remote_ne i_ooc_remote_ne (
        .mclk, .rx_frame, .rx_mfas, .rx_pm_b3, .rx_tcm_b3, .rx_aps_b0,
        .rx_psi0, .rx_ftfl_byte
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // one idle cycle after the strobe so back to back calls never collide
    task automatic tx_pulse(input logic [7:0] mfas);
        tx_mfas = mfas;
        tx_frame = 1'b1;
        @(negedge mclk);
        tx_frame = 1'b0;
        @(negedge mclk);
    endtask : tx_pulse

    function automatic logic [7:0] fdec(input logic [7:0] b);
        return (b < 8'h03) ? b : 8'h03;
    endfunction : fdec

    task automatic t_reset();
        chk(tx_pm_b3, 8'h01);
        chk(tx_psi0, 8'hFF);
        chk(8'(rx_bdi), 8'h00);
        chk(8'(rx_tcm_stat), 8'(ooc_pkg::TCS_NOSRC));
    endtask : t_reset

    task automatic t_tx();
        logic [3:0] bei;
        for (int i = 0; i < 12; i++) begin
            bei = (i > 8) ? 4'h8 : 4'(i);
            bip_err_cnt = 4'(i);
            sig_fail = i[0];
            pm_maint = ooc_pkg::ooc_maint_t'(i % 4);
            tcm_mode = ooc_pkg::ooc_tcm_stat_t'(i % 7);
            aps_req = 4'(i);
            aps_ptype = 4'(11 - i);
            psi_select = ooc_pkg::ooc_psi_t'(i % 11);
            tx_pulse(8'(i));
            chk(tx_pm_b3, {bei, i[0], PM_TX[i % 4]});
            chk(tx_tcm_b3, {bei, i[0], TCM_TX[i % 7]});
            chk(tx_aps_b0, {4'(i), 4'(11 - i)});
            chk(tx_psi0, PSI_TX[i % 11]);
        end
        psi_direct = 1'b1;
        psi_value = 8'h1C;
        tx_pulse(8'h00);
        chk(tx_psi0, 8'h1C);
    endtask : t_tx

    task automatic t_msg();
        int ms [6] = '{0, 63, 64, 69, 128, 255};
        wr_en = 1'b1;
        // index 64 is beyond the trace and must leave byte 0 alone
        for (int a = 0; a < 321; a++) begin
            wr_ftfl = (a > 64);
            wr_addr = (a > 64) ? 8'(a - 65) : 8'(a);
            wr_data = (a == 64) ? 8'h00 : wr_addr ^ {wr_ftfl, 7'h25};
            @(negedge mclk);
        end
        wr_en = 1'b0;
        foreach (ms[k]) begin
            tx_pulse(8'(ms[k]));
            chk(tx_tti_byte, 8'(ms[k] % 64) ^ 8'h25);
            chk(tx_ftfl_byte, 8'(ms[k]) ^ 8'hA5);
        end
    endtask : t_msg

    task automatic t_rx();
        logic [3:0] n;
        for (int i = 0; i < 16; i++) begin
            n = 4'(i);
            i_ooc_remote_ne.send_frame(8'h05, {n, n[0], n[2:0]},
                {n, ~n[0], n[2:0]}, {n, ~n}, PSI_IN[i], 8'h00);
            chk(8'(rx_bei), (i > 8) ? 8'h00 : 8'(i));
            chk(8'(rx_bdi), 8'(n[0]));
            chk(8'(rx_pm_stat), 8'(PM_DEC[i % 8]));
            chk(8'(rx_tcm_stat), 8'(TCM_DEC[i % 8]));
            chk(8'(rx_aps), 8'(APS_DEC[i]));
            chk(8'(rx_ptype), {4'h0, ~n});
            chk(8'(rx_psi), 8'(PSI_DEC[i]));
        end
    endtask : t_rx

    task automatic ftfl_pass(input logic [7:0] fb, bb, c2, input int n);
        logic [7:0] b;
        for (int m = 0; m < 11; m++) begin
            b = (m == 0) ? fb : (m == 2) ? c2 : (m < 4) ? 8'(8'h40 + m) :
                (m - 4 < n) ? 8'h4E : 8'h00;
            i_ooc_remote_ne.send_frame(8'(m), 8'h20, 8'h00, 8'h00, 8'hFD, b);
        end
        chk(8'(rx_fwd_fault), fdec(fb));
        chk(8'(rx_cc_ok), 8'(c2 >= 8'h41 && c2 <= 8'h5A));
        chk(8'(rx_nsc_len), 8'(n));
        chk(8'(rx_nsc_ok), 8'(n > 0));
        i_ooc_remote_ne.send_frame(8'h80, 8'h20, 8'h00, 8'h00, 8'hFD, bb);
        chk(8'(rx_bwd_fault), fdec(bb));
    endtask : ftfl_pass

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        // fill the memories first so no unknown byte reaches a tx output
        t_msg();
        t_tx();
        t_rx();
        ftfl_pass(8'h01, 8'h02, 8'h42, 2);
        ftfl_pass(8'h03, 8'h00, 8'h31, 0);
        ftfl_pass(8'h02, 8'hFF, 8'h5A, 6);
        test_done();
    end
endmodule : odu_overhead_field_codec_tb_top

// ---- ooc_codec.sv ----
// odu/opu overhead field encoder and decoder
// assumes frame strobes and mfas come from the host framer, same clock
// Summary of operation
// RULE1: tcm status codes 000..111 with reserved
// RULE2: pm stat 001 normal, 101/110/111 maintenance
// RULE3: ftfl holds forward and backward 128-byte halves
// RULE4: fault byte 00 none, 01 sf, 02 sd
// RULE5: country code is exactly three characters
// RULE6: national segment code one to six characters
// RULE7: pm third byte bei, bdi, stat layout
// RULE8: 64-byte trace, byte per frame, multiframe aligned
// RULE9: trace holds sapi, dapi, 32-byte operator part
// RULE10: bei 0..8 binary, 1001..1111 read zero
// RULE11: sent bei equals local bip-8 block errors
// RULE12: bdi high exactly while signal fail
// RULE13: aps byte: request bits 1-4, type 5-8
// RULE14: aps request nibble codes, others reserved
// RULE15: psi byte zero direct or selected code
// RULE16: codes 01..1C are client mappings
// RULE17: 20 amp-only mux, 21 gmp-capable mux
// RULE18: 80 proprietary mapping
// RULE19: fd null, fe prbs; 55/66/ff not available
// RULE20: reserved received codes reported as reserved
`timescale 1ns/1ps
`include "ooc_defs.svh"
module ooc_codec #(
    parameter int TTI_LEN  = `OOC_TTI_LEN,
    parameter int FTFL_LEN = `OOC_FTFL_LEN
) (
    input  wire logic                 mclk,          // 200 MHz clock
    input  wire logic                 rst_n,         // sync reset
    input  wire logic                 tx_frame,      // tx frame strobe
    input  wire logic [7:0]           tx_mfas,       // tx multiframe count
    input  wire logic                 sig_fail,      // local signal fail
    input  wire logic [3:0]           bip_err_cnt,   // local bip-8 errors
    input  wire ooc_pkg::ooc_maint_t  pm_maint,      // pm maintenance
    input  wire ooc_pkg::ooc_tcm_stat_t tcm_mode,    // tcm status to send
    input  wire logic [3:0]           aps_req,       // aps request code
    input  wire logic [3:0]           aps_ptype,     // protection type
    input  wire logic                 psi_direct,    // use psi_value
    input  wire logic [7:0]           psi_value,     // direct psi byte
    input  wire ooc_pkg::ooc_psi_t    psi_select,    // selected payload
    input  wire logic                 wr_en,         // message write
    input  wire logic                 wr_ftfl,       // 1 ftfl, 0 trace
    input  wire logic [7:0]           wr_addr,       // byte index
    input  wire logic [7:0]           wr_data,       // byte value
    output logic [7:0]                tx_pm_b3,      // pm third byte
    output logic [7:0]                tx_tcm_b3,     // tcm third byte
    output logic [7:0]                tx_aps_b0,     // aps first byte
    output logic [7:0]                tx_psi0,       // psi byte zero
    output logic [7:0]                tx_tti_byte,   // trace byte
    output logic [7:0]                tx_ftfl_byte,  // ftfl byte
    input  wire logic                 rx_frame,      // rx frame strobe
    input  wire logic [7:0]           rx_mfas,       // rx multiframe count
    input  wire logic [7:0]           rx_pm_b3,      // rx pm third byte
    input  wire logic [7:0]           rx_tcm_b3,     // rx tcm third byte
    input  wire logic [7:0]           rx_aps_b0,     // rx aps first byte
    input  wire logic [7:0]           rx_psi0,       // rx psi byte zero
    input  wire logic [7:0]           rx_ftfl_byte,  // rx ftfl byte
    output logic [3:0]                rx_bei,        // bip violations
    output logic                      rx_bdi,        // remote defect
    output ooc_pkg::ooc_pm_stat_t     rx_pm_stat,    // pm status
    output ooc_pkg::ooc_tcm_stat_t    rx_tcm_stat,   // tcm status
    output ooc_pkg::ooc_aps_t         rx_aps,        // aps request
    output logic [3:0]                rx_ptype,      // protection type
    output ooc_pkg::ooc_psi_t         rx_psi,        // payload class
    output ooc_pkg::ooc_fault_t       rx_fwd_fault,  // forward fault
    output ooc_pkg::ooc_fault_t       rx_bwd_fault,  // backward fault
    output logic                      rx_cc_ok,      // country code valid
    output logic [2:0]                rx_nsc_len,    // carrier code length
    output logic                      rx_nsc_ok      // length 1..6
);
    logic [7:0] tti_mem [TTI_LEN];
    logic [7:0] ftfl_mem [FTFL_LEN];
    logic [3:0] bei_d;
    logic [2:0] pm_stat_d;
    logic [2:0] tcm_stat_d;
    logic [7:0] psi_sel_d;
    logic [7:0] rx_idx;
    logic       rx_half_b;
    logic [6:0] rx_off;
    logic       cc_q;
    logic       nsc_run_q;
    logic [2:0] nsc_cnt_q;

    // message store: sapi 0-15, dapi 16-31, operator 32-63
    always_ff @(posedge mclk) begin
        if (wr_en && !wr_ftfl && wr_addr < 8'(TTI_LEN)) begin // RULE9
            tti_mem[wr_addr[5:0]] <= wr_data;
        end
        if (wr_en && wr_ftfl) begin // RULE3
            ftfl_mem[wr_addr] <= wr_data;
        end
    end

    // counts above eight cannot occur for bip-8; clamp anyway
    always_comb begin
        bei_d = (bip_err_cnt > `OOC_BEI_MAX) ? `OOC_BEI_MAX
                                              : bip_err_cnt; // RULE11
        unique case (pm_maint)
            ooc_pkg::MNT_NORMAL: pm_stat_d = `OOC_STAT_NORMAL; // RULE2
            ooc_pkg::MNT_LCK:    pm_stat_d = `OOC_STAT_LCK;
            ooc_pkg::MNT_OCI:    pm_stat_d = `OOC_STAT_OCI;
            ooc_pkg::MNT_AIS:    pm_stat_d = `OOC_STAT_AIS;
        endcase
        unique case (tcm_mode)
            ooc_pkg::TCS_NOSRC: tcm_stat_d = `OOC_STAT_NOSRC; // RULE1
            ooc_pkg::TCS_NOIAE: tcm_stat_d = `OOC_STAT_NOIAE;
            ooc_pkg::TCS_IAE:   tcm_stat_d = `OOC_STAT_IAE;
            ooc_pkg::TCS_LCK:   tcm_stat_d = `OOC_STAT_LCK;
            ooc_pkg::TCS_OCI:   tcm_stat_d = `OOC_STAT_OCI;
            ooc_pkg::TCS_AIS:   tcm_stat_d = `OOC_STAT_AIS;
            default:            tcm_stat_d = `OOC_STAT_NOSRC;
        endcase
        unique case (psi_select)
            ooc_pkg::PSI_ASYNC: psi_sel_d = `OOC_PT_ASYNC; // RULE16
            ooc_pkg::PSI_BSYNC: psi_sel_d = `OOC_PT_BSYNC;
            ooc_pkg::PSI_GFP:   psi_sel_d = `OOC_PT_GFP;
            ooc_pkg::PSI_AMP:   psi_sel_d = `OOC_PT_AMP; // RULE17
            ooc_pkg::PSI_GMP:   psi_sel_d = `OOC_PT_GMP;
            ooc_pkg::PSI_PROP:  psi_sel_d = `OOC_PT_PROP; // RULE18
            ooc_pkg::PSI_NULL:  psi_sel_d = `OOC_PT_NULL; // RULE19
            ooc_pkg::PSI_PRBS:  psi_sel_d = `OOC_PT_PRBS;
            default:            psi_sel_d = `OOC_PT_NA3;
        endcase
    end

    // overhead bytes change only at frame boundaries
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_pm_b3  <= {4'h0, 1'b0, `OOC_STAT_NORMAL};
            tx_tcm_b3 <= 8'h00;
            tx_aps_b0 <= 8'h00;
            tx_psi0   <= `OOC_PT_NA3;
        end else if (tx_frame) begin
            tx_pm_b3  <= {bei_d, sig_fail, pm_stat_d}; // RULE7 RULE12
            tx_tcm_b3 <= {bei_d, sig_fail, tcm_stat_d}; // RULE1
            tx_aps_b0 <= {aps_req, aps_ptype}; // RULE13
            tx_psi0   <= psi_direct ? psi_value : psi_sel_d; // RULE15
        end
    end

    // trace index follows mfas so byte 0 lands on multiframe start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_tti_byte  <= 8'h00;
            tx_ftfl_byte <= 8'h00;
        end else if (tx_frame) begin
            tx_tti_byte  <= tti_mem[tx_mfas[5:0]]; // RULE8
            tx_ftfl_byte <= ftfl_mem[tx_mfas]; // RULE3
        end
    end

    function automatic ooc_pkg::ooc_fault_t fault_dec(input logic [7:0] b);
        ooc_pkg::ooc_fault_t f;
        f = ooc_pkg::FLT_RSVD;
        if (b == `OOC_FI_NONE) f = ooc_pkg::FLT_NONE; // RULE4
        if (b == `OOC_FI_SF)   f = ooc_pkg::FLT_SF;
        if (b == `OOC_FI_SD)   f = ooc_pkg::FLT_SD;
        return f;
    endfunction : fault_dec

    function automatic ooc_pkg::ooc_pm_stat_t pm_dec(input logic [2:0] s);
        ooc_pkg::ooc_pm_stat_t p;
        p = ooc_pkg::PMS_RSVD; // RULE20
        if (s == `OOC_STAT_NORMAL) p = ooc_pkg::PMS_NORMAL; // RULE2
        if (s == `OOC_STAT_LCK)    p = ooc_pkg::PMS_LCK;
        if (s == `OOC_STAT_OCI)    p = ooc_pkg::PMS_OCI;
        if (s == `OOC_STAT_AIS)    p = ooc_pkg::PMS_AIS;
        return p;
    endfunction : pm_dec

    function automatic ooc_pkg::ooc_tcm_stat_t tcm_dec(input logic [2:0] s);
        ooc_pkg::ooc_tcm_stat_t t;
        t = ooc_pkg::TCS_RSVD; // RULE20
        if (s == `OOC_STAT_NOSRC) t = ooc_pkg::TCS_NOSRC; // RULE1
        if (s == `OOC_STAT_NOIAE) t = ooc_pkg::TCS_NOIAE;
        if (s == `OOC_STAT_IAE)   t = ooc_pkg::TCS_IAE;
        if (s == `OOC_STAT_LCK)   t = ooc_pkg::TCS_LCK;
        if (s == `OOC_STAT_OCI)   t = ooc_pkg::TCS_OCI;
        if (s == `OOC_STAT_AIS)   t = ooc_pkg::TCS_AIS;
        return t;
    endfunction : tcm_dec

    function automatic ooc_pkg::ooc_aps_t aps_dec(input logic [3:0] r);
        ooc_pkg::ooc_aps_t a;
        a = ooc_pkg::APS_RSVD; // RULE20
        if (r == `OOC_APS_NR)   a = ooc_pkg::APS_NR; // RULE14
        if (r == `OOC_APS_DNR)  a = ooc_pkg::APS_DNR;
        if (r == `OOC_APS_RR)   a = ooc_pkg::APS_RR;
        if (r == `OOC_APS_EXER) a = ooc_pkg::APS_EXER;
        if (r == `OOC_APS_WT)   a = ooc_pkg::APS_WT;
        if (r == `OOC_APS_MS)   a = ooc_pkg::APS_MS;
        if (r == `OOC_APS_SD)   a = ooc_pkg::APS_SD;
        if (r == `OOC_APS_SF)   a = ooc_pkg::APS_SF;
        if (r == `OOC_APS_FS)   a = ooc_pkg::APS_FS;
        if (r == `OOC_APS_LO)   a = ooc_pkg::APS_LO;
        return a;
    endfunction : aps_dec

    function automatic ooc_pkg::ooc_psi_t psi_dec(input logic [7:0] v);
        ooc_pkg::ooc_psi_t c;
        c = ooc_pkg::PSI_RSVD; // RULE20
        if (v >= `OOC_PT_FIRST && v <= `OOC_PT_LAST)
            c = ooc_pkg::PSI_CLIENT; // RULE16
        if (v == `OOC_PT_ASYNC) c = ooc_pkg::PSI_ASYNC;
        if (v == `OOC_PT_BSYNC) c = ooc_pkg::PSI_BSYNC;
        if (v == `OOC_PT_GFP)   c = ooc_pkg::PSI_GFP;
        if (v == `OOC_PT_AMP)   c = ooc_pkg::PSI_AMP; // RULE17
        if (v == `OOC_PT_GMP)   c = ooc_pkg::PSI_GMP;
        if (v == `OOC_PT_PROP)  c = ooc_pkg::PSI_PROP; // RULE18
        if (v == `OOC_PT_NULL)  c = ooc_pkg::PSI_NULL; // RULE19
        if (v == `OOC_PT_PRBS)  c = ooc_pkg::PSI_PRBS;
        if (v == `OOC_PT_NA1 || v == `OOC_PT_NA2 || v == `OOC_PT_NA3)
            c = ooc_pkg::PSI_NA;
        return c;
    endfunction : psi_dec

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_bei      <= 4'h0;
            rx_bdi      <= 1'b0;
            rx_pm_stat  <= ooc_pkg::PMS_NORMAL;
            rx_tcm_stat <= ooc_pkg::TCS_NOSRC;
            rx_aps      <= ooc_pkg::APS_NR;
            rx_ptype    <= 4'h0;
            rx_psi      <= ooc_pkg::PSI_NA;
        end else if (rx_frame) begin
            rx_bei      <= (rx_pm_b3[7:4] > `OOC_BEI_MAX) ? 4'h0 // RULE10
                                                           : rx_pm_b3[7:4];
            rx_bdi      <= rx_pm_b3[3]; // RULE7
            rx_pm_stat  <= pm_dec(rx_pm_b3[2:0]);
            rx_tcm_stat <= tcm_dec(rx_tcm_b3[2:0]);
            rx_aps      <= aps_dec(rx_aps_b0[7:4]); // RULE13
            rx_ptype    <= rx_aps_b0[3:0];
            rx_psi      <= psi_dec(rx_psi0); // RULE15
        end
    end

    // received ftfl: offset within each half selects the field
    assign rx_idx    = rx_mfas;
    assign rx_half_b = rx_idx[7];
    assign rx_off    = rx_idx[6:0];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_fwd_fault <= ooc_pkg::FLT_NONE;
            rx_bwd_fault <= ooc_pkg::FLT_NONE;
        end else if (rx_frame && rx_off == 7'h00) begin
            if (rx_half_b) begin
                rx_bwd_fault <= fault_dec(rx_ftfl_byte); // RULE4
            end else begin
                rx_fwd_fault <= fault_dec(rx_ftfl_byte);
            end
        end
    end

    // only the forward operator identifier is checked; limitation
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cc_q       <= 1'b0;
            rx_cc_ok   <= 1'b0;
            nsc_run_q  <= 1'b0;
            nsc_cnt_q  <= 3'h0;
            rx_nsc_len <= 3'h0;
            rx_nsc_ok  <= 1'b0;
        end else if (rx_frame && !rx_half_b) begin
            if (rx_off >= `OOC_CC_FIRST
                && rx_off <= `OOC_CC_LAST) begin
                cc_q <= (rx_off == `OOC_CC_FIRST || cc_q)
                        && rx_ftfl_byte >= `OOC_CH_A
                        && rx_ftfl_byte <= `OOC_CH_Z; // RULE5
                if (rx_off == `OOC_CC_LAST) begin
                    rx_cc_ok <= (cc_q || rx_off == `OOC_CC_FIRST)
                                && rx_ftfl_byte >= `OOC_CH_A
                                && rx_ftfl_byte <= `OOC_CH_Z;
                end
            end
            if (rx_off == `OOC_NSC_FIRST) begin
                nsc_run_q <= (rx_ftfl_byte != 8'h00);
                nsc_cnt_q <= (rx_ftfl_byte != 8'h00) ? 3'h1 : 3'h0;
            end else if (rx_off > `OOC_NSC_FIRST
                         && rx_off <= `OOC_NSC_LAST) begin
                if (nsc_run_q && rx_ftfl_byte != 8'h00) begin
                    nsc_cnt_q <= nsc_cnt_q + 3'h1;
                end else begin
                    nsc_run_q <= 1'b0;
                end
            end else if (rx_off == `OOC_NSC_LAST + 7'h01) begin
                rx_nsc_len <= nsc_cnt_q;
                rx_nsc_ok  <= nsc_cnt_q != 3'h0
                              && nsc_cnt_q <= `OOC_NSC_MAX; // RULE6
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence tx_idle_s;
        !tx_frame ##1 1'b1;
    endsequence

    bdi_follows_sf_a: assert property ( // RULE12
        tx_frame |=> tx_pm_b3[3] == $past(sig_fail))
        else $error("pm bdi does not follow signal fail");
    bei_clamp_a: assert property ( // RULE11
        tx_frame |=> tx_pm_b3[7:4] <= `OOC_BEI_MAX
        && (tx_pm_b3[7:4] == $past(bip_err_cnt)
            || $past(bip_err_cnt) > `OOC_BEI_MAX))
        else $error("sent bei differs from local error count");
    pm_stat_code_a: assert property ( // RULE2
        tx_frame && pm_maint == ooc_pkg::MNT_NORMAL |=>
        tx_pm_b3[2:0] == `OOC_STAT_NORMAL)
        else $error("normal path status not 001");
    tcm_ais_code_a: assert property ( // RULE1
        tx_frame && tcm_mode == ooc_pkg::TCS_AIS |=>
        tx_tcm_b3[2:0] == `OOC_STAT_AIS)
        else $error("tcm ais status not 111");
    psi_direct_a: assert property ( // RULE15
        tx_frame && psi_direct |=> tx_psi0 == $past(psi_value))
        else $error("direct psi value not sent");
    tx_hold_a: assert property ( // RULE13
        !tx_frame |=> $stable(tx_aps_b0) && $stable(tx_psi0))
        else $error("overhead byte changed between frames");
    bei_invalid_a: assert property ( // RULE10
        rx_frame && rx_pm_b3[7:4] > `OOC_BEI_MAX |=> rx_bei == 4'h0)
        else $error("invalid bei not read as zero");
    aps_rsvd_a: assert property ( // RULE14
        rx_frame && rx_aps_b0[7:4] == 4'h3 |=>
        rx_aps == ooc_pkg::APS_RSVD)
        else $error("reserved aps code not flagged");
    fault_rsvd_a: assert property ( // RULE4
        rx_frame && rx_idx == 8'h00 && rx_ftfl_byte > `OOC_FI_SD |=>
        rx_fwd_fault == ooc_pkg::FLT_RSVD)
        else $error("reserved fault byte not flagged");
    psi_na_a: assert property ( // RULE19
        rx_frame && rx_psi0 == `OOC_PT_NA2 |=> rx_psi == ooc_pkg::PSI_NA)
        else $error("not-available psi misread");
    tick_align_a: assert property ( // RULE8
        tx_idle_s |-> $stable(tx_tti_byte) && $stable(tx_ftfl_byte))
        else $error("trace byte changed without frame");
endmodule : ooc_codec

// ---- ooc_defs.svh ----
// codes and layout constants for the odu overhead field codec
// assumes overhead bytes use bit 1 = msb numbering
`ifndef OOC_DEFS_SVH
`define OOC_DEFS_SVH
`define OOC_TTI_LEN      64
`define OOC_FTFL_HALF    128
`define OOC_FTFL_LEN     256
`define OOC_OP_PART      32
`define OOC_CC_FIRST     7'h01
`define OOC_CC_LAST      7'h03
`define OOC_NSC_FIRST    7'h04
`define OOC_NSC_LAST     7'h09
`define OOC_NSC_MAX      3'h6
`define OOC_BEI_MAX      4'h8
`define OOC_STAT_NOSRC   3'h0
`define OOC_STAT_NOIAE   3'h1
`define OOC_STAT_IAE     3'h2
`define OOC_STAT_NORMAL  3'h1
`define OOC_STAT_LCK     3'h5
`define OOC_STAT_OCI     3'h6
`define OOC_STAT_AIS     3'h7
`define OOC_FI_NONE      8'h00
`define OOC_FI_SF        8'h01
`define OOC_FI_SD        8'h02
`define OOC_APS_NR       4'h0
`define OOC_APS_DNR      4'h1
`define OOC_APS_RR       4'h2
`define OOC_APS_EXER     4'h4
`define OOC_APS_WT       4'h6
`define OOC_APS_MS       4'h8
`define OOC_APS_SD       4'hA
`define OOC_APS_SF       4'hC
`define OOC_APS_FS       4'hE
`define OOC_APS_LO       4'hF
`define OOC_PT_FIRST     8'h01
`define OOC_PT_ASYNC     8'h02
`define OOC_PT_BSYNC     8'h03
`define OOC_PT_GFP       8'h05
`define OOC_PT_LAST      8'h1C
`define OOC_PT_AMP       8'h20
`define OOC_PT_GMP       8'h21
`define OOC_PT_NA1       8'h55
`define OOC_PT_NA2       8'h66
`define OOC_PT_PROP      8'h80
`define OOC_PT_NULL      8'hFD
`define OOC_PT_PRBS      8'hFE
`define OOC_PT_NA3       8'hFF
`define OOC_CH_A         8'h41
`define OOC_CH_Z         8'h5A
`endif

// ---- ooc_pkg.sv ----
// types shared by the odu overhead field codec
// assumes ooc_defs.svh supplies the numeric codes
package ooc_pkg;
    typedef enum logic [1:0] {MNT_NORMAL, MNT_LCK, MNT_OCI, MNT_AIS}
        ooc_maint_t;
    typedef enum logic [2:0] {TCS_NOSRC, TCS_NOIAE, TCS_IAE, TCS_LCK,
        TCS_OCI, TCS_AIS, TCS_RSVD} ooc_tcm_stat_t;
    typedef enum logic [2:0] {PMS_NORMAL, PMS_LCK, PMS_OCI, PMS_AIS,
        PMS_RSVD} ooc_pm_stat_t;
    typedef enum logic [1:0] {FLT_NONE, FLT_SF, FLT_SD, FLT_RSVD}
        ooc_fault_t;
    typedef enum logic [3:0] {APS_NR, APS_DNR, APS_RR, APS_EXER, APS_WT,
        APS_MS, APS_SD, APS_SF, APS_FS, APS_LO, APS_RSVD} ooc_aps_t;
    typedef enum logic [3:0] {PSI_ASYNC, PSI_BSYNC, PSI_GFP, PSI_AMP,
        PSI_GMP, PSI_PROP, PSI_NULL, PSI_PRBS, PSI_CLIENT, PSI_NA,
        PSI_RSVD} ooc_psi_t;
endpackage : ooc_pkg

// ---- ooc_remote_ne.sv ----
// far network element model driving the codec's receive overhead bytes
// assumes the bench calls send_frame from a task that sits at a negedge
`timescale 1ns/1ps
module ooc_remote_ne (
    input  wire logic  mclk,                 // codec clock
    output logic       rx_frame     = 1'b0,  // frame strobe
    output logic [7:0] rx_mfas      = 8'h00, // multiframe count
    output logic [7:0] rx_pm_b3     = 8'h00, // pm third byte
    output logic [7:0] rx_tcm_b3    = 8'h00, // tcm third byte
    output logic [7:0] rx_aps_b0    = 8'h00, // aps first byte
    output logic [7:0] rx_psi0      = 8'h00, // psi byte zero
    output logic [7:0] rx_ftfl_byte = 8'h00  // ftfl byte
);
    task automatic send_frame(input logic [7:0] mfas, pm, tcm, aps, psi,
                              input logic [7:0] ftfl);
        @(negedge mclk);
        rx_frame = 1'b1;
        rx_mfas = mfas;
        rx_pm_b3 = pm;
        rx_tcm_b3 = tcm;
        rx_aps_b0 = aps;
        rx_psi0 = psi;
        rx_ftfl_byte = ftfl;
        @(negedge mclk);
        // junk between frames so a stale byte can never pass for fresh
        rx_frame = 1'b0;
        rx_mfas = ~mfas;
        rx_pm_b3 = ~pm;
        rx_tcm_b3 = ~tcm;
        rx_aps_b0 = ~aps;
        rx_psi0 = ~psi;
        rx_ftfl_byte = ~ftfl;
    endtask : send_frame
endmodule : ooc_remote_ne
